// file: common/flash_sector_map.svh
`ifndef FLASH_SECTOR_MAP_SVH
`define FLASH_SECTOR_MAP_SVH

// --------------------------------------------------------------
// register offsets
// --------------------------------------------------------------
`define OP_CTRL_HIGH_OFS 24'h0e0002
`define SEL_LOW_OFS      24'h0e0004
`define SEL_HIGH_OFS     24'h0e0006

// --------------------------------------------------------------
// field positions and widths
// --------------------------------------------------------------
`define MOD_SEL_BIT      0
`define BANK_LO_STAT_BIT 8
`define BANK_HI_STAT_BIT 9
`define EXT_LO_SECTORS   3
`define MAIN_LO_SECTORS  10
`define HI_SECTORS       2

// --------------------------------------------------------------
// reset values
// --------------------------------------------------------------
`define SEL_RESET        16'h0000
`define MOD_SEL_RESET    1'b0

`endif

// file: common/flash_sector_pkg.sv
package flash_sector_pkg;

    // register port request
    typedef struct packed {
        logic [23:0] addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } bus_req_s;

    // events and flags from the write controller
    typedef struct packed {
        logic op_start;
        logic op_erase;
        logic op_done;
        logic error_flag;
        logic suspend_flag;
    } ctl_in_s;

    // status bits split by meaning
    typedef struct packed {
        logic [15:0] err_low;
        logic [15:0] err_high;
        logic [15:0] suspend_flag_low;
        logic [15:0] suspend_flag_high;
    } meaning_s;

    typedef enum logic [1:0] {
        OP_IDLE,
        OP_ERASE,
        OP_PROG
    } op_state_e;

endpackage : flash_sector_pkg

// file: dv/testbench.sv
`timescale 1ns/100ps
`include "flash_sector_map.svh"

`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin err_total++; \
    $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end

module testbench;

    logic                       sys_clk;
    logic                       arst_n;
    flash_sector_pkg::bus_req_s bus;
    flash_sector_pkg::ctl_in_s  ctl;
    logic                [15:0] rd_data;
    logic                       module_select;
    logic                       erase_active;
    flash_sector_pkg::meaning_s meaning;
    int                         err_total;
    int                         total_checks;
    int                         cycles;

    flash_sector_select_status i_dut (
        .sys_clk       (sys_clk),
        .arst_n        (arst_n),
        .bus           (bus),
        .rd_data       (rd_data),
        .ctl           (ctl),
        .module_select (module_select),
        .erase_active  (erase_active),
        .meaning       (meaning)
    );

    // ----------------------------------------------------------
    // clock and hang guard
    // ----------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // whole run is under a hundred cycles; ceiling leaves wide margin
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            finish_test();
        end
    end

    // ----------------------------------------------------------
    // bus and controller tasks
    // ----------------------------------------------------------
    task automatic wr(input logic [23:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        bus.addr  <= a;
        bus.wdata <= d;
        bus.wr    <= 1'b1;
        @(posedge sys_clk);
        bus.wr    <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic chk_reg(input logic [23:0] a, input logic [15:0] exp, input string nm);
        @(posedge sys_clk);
        bus.addr <= a;
        bus.rd   <= 1'b1;
        @(posedge sys_clk);
        bus.rd   <= 1'b0;
        #1;
        `CHK(nm, exp, rd_data)
    endtask : chk_reg

    task automatic op_pulse(input logic start, input logic erase, input logic done);
        @(posedge sys_clk);
        ctl.op_start <= start;
        ctl.op_erase <= erase;
        ctl.op_done  <= done;
        @(posedge sys_clk);
        ctl.op_start <= 1'b0;
        ctl.op_done  <= 1'b0;
        #1;
    endtask : op_pulse

    // meaning is registered, so let two edges pass before looking
    task automatic chk_meaning(input logic [63:0] exp);
        repeat (2) @(posedge sys_clk);
        #1;
        `CHK("meaning", exp, meaning)
    endtask : chk_meaning

    // ----------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------
    task automatic test_reset_and_map;
        `CHK("module_select", 1'b0, module_select)
        chk_reg(`SEL_LOW_OFS, `SEL_RESET, "low reset");
        chk_reg(`SEL_HIGH_OFS, `SEL_RESET, "high reset");
        chk_reg(24'h0e0008, 16'h0000, "unmapped");
        @(posedge sys_clk);
        #1;
        `CHK("rd_data idle", 16'h0000, rd_data)
        wr(`SEL_LOW_OFS, 16'hffff);
        wr(`SEL_HIGH_OFS, 16'hffff);
        chk_reg(`SEL_LOW_OFS, 16'h0007, "ext low");
        chk_reg(`SEL_HIGH_OFS, 16'h0003, "ext high");
        wr(`OP_CTRL_HIGH_OFS, 16'hffff);
        chk_reg(`OP_CTRL_HIGH_OFS, 16'h0001, "op ctrl");
        `CHK("module_select", 1'b1, module_select)
        chk_reg(`SEL_LOW_OFS, 16'h0000, "main low");
        wr(`SEL_LOW_OFS, 16'hffff);
        wr(`SEL_HIGH_OFS, 16'h0003);
        chk_reg(`SEL_LOW_OFS, 16'h03ff, "main low");
        $display("test reset_and_map done");
    endtask : test_reset_and_map

    task automatic test_main_error;
        op_pulse(1'b1, 1'b1, 1'b0);
        `CHK("erase_active", 1'b1, erase_active)
        @(posedge sys_clk);
        ctl.error_flag <= 1'b1;
        ctl.suspend_flag <= 1'b1;
        chk_meaning({16'h03ff, 16'h0303, 32'h0});
        op_pulse(1'b0, 1'b0, 1'b1);
        `CHK("erase_active", 1'b0, erase_active)
        `CHK("module_select", 1'b0, module_select)
        @(posedge sys_clk);
        ctl.error_flag <= 1'b0;
        ctl.suspend_flag <= 1'b0;
        wr(`OP_CTRL_HIGH_OFS, 16'h0001);
        chk_reg(`SEL_LOW_OFS, 16'h03ff, "main low kept");
        chk_reg(`SEL_HIGH_OFS, 16'h0303, "main high kept");
        $display("test main_error done");
    endtask : test_main_error

    task automatic test_ext_suspend;
        wr(`OP_CTRL_HIGH_OFS, 16'h0000);
        chk_reg(`SEL_HIGH_OFS, 16'h0003, "ext high");
        op_pulse(1'b1, 1'b1, 1'b0);
        @(posedge sys_clk);
        ctl.suspend_flag <= 1'b1;
        chk_meaning({32'h0, 16'h0007, 16'h0303});
        chk_reg(`SEL_HIGH_OFS, 16'h0303, "ext banks");
        @(posedge sys_clk);
        ctl.suspend_flag <= 1'b0;
        chk_meaning(64'h0);
        op_pulse(1'b0, 1'b0, 1'b1);
        chk_reg(`SEL_LOW_OFS, 16'h0000, "ext low clear");
        chk_reg(`SEL_HIGH_OFS, 16'h0000, "ext high clear");
        wr(`OP_CTRL_HIGH_OFS, 16'h0001);
        chk_reg(`SEL_LOW_OFS, 16'h03ff, "main untouched");
        $display("test ext_suspend done");
    endtask : test_ext_suspend

    task automatic test_program_clear;
        op_pulse(1'b1, 1'b0, 1'b0);
        `CHK("erase_active", 1'b0, erase_active)
        op_pulse(1'b0, 1'b0, 1'b1);
        chk_reg(`SEL_LOW_OFS, 16'h0000, "prog clear");
        `CHK("module_select", 1'b0, module_select)
        wr(`OP_CTRL_HIGH_OFS, 16'h0001);
        chk_reg(`SEL_LOW_OFS, 16'h0000, "prog main low");
        chk_reg(`SEL_HIGH_OFS, 16'h0000, "prog main high");
        $display("test program_clear done");
    endtask : test_program_clear

    // ----------------------------------------------------------
    // verdict
    // ----------------------------------------------------------
    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : finish_test

    initial begin
        err_total    = 0;
        total_checks = 0;
        cycles       = 0;
        arst_n       = 1'b0;
        bus          = '0;
        ctl          = '0;
        repeat (8) @(posedge sys_clk);
        arst_n <= 1'b1;
        test_reset_and_map();
        test_main_error();
        test_ext_suspend();
        test_program_clear();
        finish_test();
    end

endmodule : testbench

// file: rtl/flash_sector_select_status.sv
`timescale 1ns/100ps
`include "flash_sector_map.svh"

module flash_sector_select_status (
    input  wire logic                       sys_clk,
    input  wire logic                       arst_n,
    input  wire flash_sector_pkg::bus_req_s bus,
    output logic                     [15:0] rd_data,
    input  wire flash_sector_pkg::ctl_in_s  ctl,
    output logic                            module_select,
    output logic                            erase_active,
    output flash_sector_pkg::meaning_s      meaning
);

    // ----------------------------------------------------------
    // state
    // ----------------------------------------------------------
    logic                        mod_sel_r;
    logic                        mod_sel_nxt;
    flash_sector_pkg::op_state_e state_r;
    flash_sector_pkg::op_state_e state_nxt;
    logic [15:0]                 rdata_r;
    logic [15:0]                 rdata_nxt;
    flash_sector_pkg::meaning_s  meaning_r;
    flash_sector_pkg::meaning_s  meaning_nxt;
    logic                        wr_ctrl;
    logic                        wr_low;
    logic                        wr_high;
    logic                        erase_run;
    logic [15:0]                 low_view  [2];
    logic [15:0]                 high_view [2];
    logic [15:0]                 cur_low;
    logic [15:0]                 cur_high;

    // address decode
    assign wr_ctrl = bus.wr && (bus.addr == `OP_CTRL_HIGH_OFS);
    assign wr_low  = bus.wr && (bus.addr == `SEL_LOW_OFS);
    assign wr_high = bus.wr && (bus.addr == `SEL_HIGH_OFS);

    // erase is no longer running in the cycle it completes
    assign erase_run = (state_r == flash_sector_pkg::OP_ERASE) && !ctl.op_done;

    // ----------------------------------------------------------
    // one status set per flash module, 0 extension, 1 main
    // ----------------------------------------------------------
    for (genvar g = 0; g < 2; g++) begin : g_mod
        sector_status_bank #(
            .LO_W (g ? `MAIN_LO_SECTORS : `EXT_LO_SECTORS),
            .HI_W (`HI_SECTORS)
        ) u_bank (
            .sys_clk    (sys_clk),
            .arst_n     (arst_n),
            .sel        (mod_sel_r == 1'(g)),
            .wr_low     (wr_low),
            .wr_high    (wr_high),
            .wdata      (bus.wdata),
            .erasing    (erase_run),
            .op_done    (ctl.op_done),
            .error_flag (ctl.error_flag),
            .low_view   (low_view[g]),
            .high_view  (high_view[g])
        );
    end

    // view of the selected module
    assign cur_low  = low_view[mod_sel_r];
    assign cur_high = high_view[mod_sel_r];

    // ----------------------------------------------------------
    // operation tracking and module select
    // ----------------------------------------------------------
    always_comb begin
        state_nxt   = state_r;
        mod_sel_nxt = mod_sel_r;
        case (state_r)
            flash_sector_pkg::OP_IDLE: begin
                if (ctl.op_start) begin
                    state_nxt = ctl.op_erase ? flash_sector_pkg::OP_ERASE
                                             : flash_sector_pkg::OP_PROG;
                end
            end
            flash_sector_pkg::OP_ERASE,
            flash_sector_pkg::OP_PROG: begin
                if (ctl.op_done) begin
                    state_nxt = flash_sector_pkg::OP_IDLE;
                end
            end
            default: begin
                state_nxt = flash_sector_pkg::OP_IDLE;
            end
        endcase
        if (ctl.op_done) begin
            mod_sel_nxt = 1'b0;
        end
        // a software write in the completion cycle wins
        if (wr_ctrl) begin
            mod_sel_nxt = bus.wdata[`MOD_SEL_BIT];
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r   <= flash_sector_pkg::OP_IDLE;
            mod_sel_r <= `MOD_SEL_RESET;
        end else begin
            state_r   <= state_nxt;
            mod_sel_r <= mod_sel_nxt;
        end
    end

    // ----------------------------------------------------------
    // read port and status meaning
    // ----------------------------------------------------------
    always_comb begin
        rdata_nxt = 16'h0000;                    // unmapped reads return zero
        if (bus.rd) begin
            case (bus.addr)
                `OP_CTRL_HIGH_OFS: rdata_nxt[`MOD_SEL_BIT] = mod_sel_r;
                `SEL_LOW_OFS:      rdata_nxt = cur_low;
                `SEL_HIGH_OFS:     rdata_nxt = cur_high;
                default:           rdata_nxt = 16'h0000;
            endcase
        end
        meaning_nxt = '0;
        // error outranks suspend; with neither flag the bits mean nothing
        if (ctl.error_flag) begin
            meaning_nxt.err_low  = cur_low;
            meaning_nxt.err_high = cur_high;
        end else if (ctl.suspend_flag) begin
            meaning_nxt.suspend_flag_low  = cur_low;
            meaning_nxt.suspend_flag_high = cur_high;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_r   <= 16'h0000;
            meaning_r <= '0;
        end else begin
            rdata_r   <= rdata_nxt;
            meaning_r <= meaning_nxt;
        end
    end

    assign rd_data       = rdata_r;
    assign meaning       = meaning_r;
    assign module_select = mod_sel_r;
    assign erase_active  = (state_r == flash_sector_pkg::OP_ERASE);

    // ----------------------------------------------------------
    // assertions
    // ----------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    sequence s_erase_quiet;
        erase_run && !bus.wr;
    endsequence

    sequence s_done_clean;
        ctl.op_done && !ctl.error_flag && !bus.wr;
    endsequence

    a_mod_sel_clear: assert property (ctl.op_done && !wr_ctrl |=> !module_select)
        else $error("module select not cleared at completion");

    a_ext_low_width: assert property (
        bus.rd && bus.addr == `SEL_LOW_OFS && !mod_sel_r
        |=> rd_data[15:3] == 13'h0000)
        else $error("extension low view too wide");

    a_main_low_width: assert property (
        bus.rd && bus.addr == `SEL_LOW_OFS && mod_sel_r
        |=> rd_data[15:10] == 6'h00 && rd_data[9:0] == $past(cur_low[9:0]))
        else $error("main low view wrong");

    a_high_reserved: assert property (
        bus.rd && bus.addr == `SEL_HIGH_OFS
        |=> rd_data[15:10] == 6'h00 && rd_data[7:2] == 6'h00)
        else $error("reserved high bits not zero");

    a_bank_lo_set: assert property (
        (s_erase_quiet and (!wr_ctrl && |cur_low))
        |=> cur_high[`BANK_LO_STAT_BIT])
        else $error("lower bank status not set");

    a_bank_hi_set: assert property (
        (s_erase_quiet and (!wr_ctrl && |cur_high[1:0]))
        |=> cur_high[`BANK_HI_STAT_BIT])
        else $error("upper bank status not set");

    a_erase_hold: assert property (
        s_erase_quiet ##1 erase_run
        |-> cur_low == $past(cur_low) && cur_high[1:0] == $past(cur_high[1:0]))
        else $error("sector bits changed during erase");

    a_clear_clean: assert property (
        s_done_clean
        |=> low_view[$past(mod_sel_r)] == 16'h0000
            && high_view[$past(mod_sel_r)] == 16'h0000)
        else $error("status not cleared after clean end");

    a_keep_error: assert property (
        ctl.op_done && ctl.error_flag && !bus.wr
        |=> low_view[$past(mod_sel_r)] == $past(cur_low))
        else $error("status lost after error");

    a_err_meaning: assert property (
        ctl.error_flag
        |=> meaning.err_low == $past(cur_low) && meaning.suspend_flag_low == 16'h0000)
        else $error("error meaning wrong");

    a_suspend_flag_meaning: assert property (
        !ctl.error_flag && ctl.suspend_flag
        |=> meaning.suspend_flag_high == $past(cur_high) && meaning.err_high == 16'h0000)
        else $error("suspend meaning wrong");

    // operation tracking, module select, read port and meaning seen from outside
    a_erase_start: assert property (
        ctl.op_start && ctl.op_erase && state_r == flash_sector_pkg::OP_IDLE
        |=> erase_active)
        else $error("erase not flagged after start");

    a_erase_stay: assert property (
        erase_active && !ctl.op_done |=> erase_active)
        else $error("erase ended without completion");

    a_mod_sel_write: assert property (
        wr_ctrl |=> module_select == $past(bus.wdata[`MOD_SEL_BIT]))
        else $error("module select write lost");

    a_rd_idle: assert property (
        !bus.rd |=> rd_data == 16'h0000)
        else $error("read data without a read");

    a_no_meaning: assert property (!ctl.error_flag && !ctl.suspend_flag |=> meaning == '0)
        else $error("meaning without flags");

endmodule : flash_sector_select_status

// file: rtl/sector_status_bank.sv
`timescale 1ns/100ps
`include "flash_sector_map.svh"

module sector_status_bank #(
    parameter int LO_W = `EXT_LO_SECTORS,
    parameter int HI_W = `HI_SECTORS
) (
    input  wire logic        sys_clk,
    input  wire logic        arst_n,
    input  wire logic        sel,
    input  wire logic        wr_low,
    input  wire logic        wr_high,
    input  wire logic [15:0] wdata,
    input  wire logic        erasing,
    input  wire logic        op_done,
    input  wire logic        error_flag,
    output logic      [15:0] low_view,
    output logic      [15:0] high_view
);

    logic [LO_W-1:0] low_r;
    logic [LO_W-1:0] low_nxt;
    logic [HI_W-1:0] hi_r;
    logic [HI_W-1:0] hi_nxt;
    logic [1:0]      bank_r;
    logic [1:0]      bank_nxt;

    // sector selection, bank status, clear on clean completion
    always_comb begin
        low_nxt  = low_r;
        hi_nxt   = hi_r;
        bank_nxt = bank_r;
        if (sel && wr_low) begin
            low_nxt = wdata[LO_W-1:0];
        end
        if (sel && wr_high) begin
            hi_nxt = wdata[HI_W-1:0];      // bank bits are hardware only
        end
        if (sel && op_done && !error_flag) begin
            low_nxt  = '0;
            hi_nxt   = '0;
            bank_nxt = 2'h0;
        end
        // set after clear so a status event is never lost
        if (sel && erasing) begin
            bank_nxt = bank_r | {|hi_nxt, |low_nxt};
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            low_r  <= '0;
            hi_r   <= '0;
            bank_r <= 2'h0;
        end else begin
            low_r  <= low_nxt;
            hi_r   <= hi_nxt;
            bank_r <= bank_nxt;
        end
    end

    // zero-filled views, reserved positions stay zero
    always_comb begin
        low_view                      = `SEL_RESET;
        high_view                     = `SEL_RESET;
        low_view[LO_W-1:0]            = low_r;
        high_view[HI_W-1:0]           = hi_r;
        high_view[`BANK_LO_STAT_BIT]  = bank_r[0];
        high_view[`BANK_HI_STAT_BIT]  = bank_r[1];
    end

endmodule : sector_status_bank
